// *** verilog/memory_primitive_pkg.sv ***
package memory_primitive_pkg;

  // ----------------------------------------------------------------
  // sizes and defaults
  // ----------------------------------------------------------------
  localparam int DEFAULT_ADDRESS_WIDTH = 16;
  localparam int DEFAULT_DATA_WIDTH = 100;
  localparam int MAX_ADDRESS_WIDTH = 16;
  localparam int MAX_DATA_WIDTH = 100;
  localparam int DEFAULT_UNKNOWN_ADDRESS_THRESHOLD = 4;
  localparam int READ_LATENCY_CYCLES = 2;
  localparam logic STATE_RESET_VALUE = 1'b0;

  // ----------------------------------------------------------------
  // variants and sequencer phases
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    VARIANT_CLOCKED_SINGLE = 2'b00,
    VARIANT_DUAL_ADDRESS = 2'b01,
    VARIANT_ADDRESS_ENABLED = 2'b10,
    VARIANT_READ_ONLY = 2'b11
  } variant_t;

  typedef enum logic [1:0] {
    PHASE_IDLE = 2'b00,
    PHASE_SCAN_READ = 2'b01,
    PHASE_SCAN_USE = 2'b10,
    PHASE_WIPE = 2'b11
  } phase_t;

  // ----------------------------------------------------------------
  // access controls travel together
  // ----------------------------------------------------------------
  typedef struct packed {
    logic chip_select;
    logic read_enable;
    logic write_enable;
    logic address_enable;
  } access_ctrl_t;

endpackage

// *** verilog/memory_word_store.sv ***
`timescale 1ns/10ps
module memory_word_store #(
  parameter int ADDRESS_WIDTH = memory_primitive_pkg::DEFAULT_ADDRESS_WIDTH,
  parameter int WORD_WIDTH = 2 * memory_primitive_pkg::DEFAULT_DATA_WIDTH
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  // write port
  input wire logic write_en,
  input wire logic [ADDRESS_WIDTH-1:0] write_address,
  input wire logic [WORD_WIDTH-1:0] write_word,
  // read port
  input wire logic [ADDRESS_WIDTH-1:0] read_address,
  output logic [WORD_WIDTH-1:0] read_word
);

  // array has no reset; it maps onto block memory
  logic [WORD_WIDTH-1:0] cells [0:(1 << ADDRESS_WIDTH)-1];

  always_ff @(posedge mclk) begin
    if (ce && write_en) begin
      cells[write_address] <= write_word;
    end
  end

  // read-old on a same-address collision; the caller bypasses
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      read_word <= '0;
    end else if (ce) begin
      read_word <= cells[read_address];
    end
  end

endmodule

// *** verilog/memory_primitive_set.sv ***
`timescale 1ns/10ps
module memory_primitive_set #(
  parameter memory_primitive_pkg::variant_t VARIANT = memory_primitive_pkg::VARIANT_CLOCKED_SINGLE,
  parameter int ADDRESS_WIDTH = memory_primitive_pkg::DEFAULT_ADDRESS_WIDTH,
  parameter int DATA_WIDTH = memory_primitive_pkg::DEFAULT_DATA_WIDTH,
  // full address space valid by default
  parameter logic [ADDRESS_WIDTH-1:0] LAST_VALID_ADDRESS = {ADDRESS_WIDTH{1'b1}},
  parameter int UNKNOWN_ADDRESS_THRESHOLD = memory_primitive_pkg::DEFAULT_UNKNOWN_ADDRESS_THRESHOLD
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  // preload image stream
  input wire logic preload_enable,
  input wire logic preload_valid,
  input wire logic preload_set_address,
  input wire logic [ADDRESS_WIDTH-1:0] preload_address,
  input wire logic [DATA_WIDTH-1:0] preload_data,
  // access
  input wire memory_primitive_pkg::access_ctrl_t ctrl,
  input wire logic [ADDRESS_WIDTH-1:0] address,
  input wire logic [ADDRESS_WIDTH-1:0] address_unknown,
  input wire logic [ADDRESS_WIDTH-1:0] read_address,
  input wire logic [ADDRESS_WIDTH-1:0] read_address_unknown,
  input wire logic [ADDRESS_WIDTH-1:0] write_address,
  input wire logic [DATA_WIDTH-1:0] write_data,
  // results
  output logic [DATA_WIDTH-1:0] data_out,
  output logic [DATA_WIDTH-1:0] data_unknown,
  output logic data_oe,
  output logic address_error,
  output logic busy
);

  localparam int AW = ADDRESS_WIDTH;
  localparam int DW = DATA_WIDTH;
  localparam int IW = ADDRESS_WIDTH + 1;
  localparam int WW = 2 * DATA_WIDTH;

  typedef struct packed {
    memory_primitive_pkg::phase_t phase;
    logic op_write;
    logic [AW-1:0] base, umask;
    logic [IW-1:0] idx, last_idx;
    logic [DW-1:0] wdata, acc, acc_unk;
    logic [AW-1:0] preload_ptr;
    logic pend_upd, pend_read, pend_bypass, pend_allx;
    logic [DW-1:0] pend_wdata;
    logic [DW-1:0] data_out, data_unknown;
    logic data_oe, address_error, busy;
  } state_t;

  state_t st, next_st;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [IW-1:0] ones(input logic [AW-1:0] mask);
    return IW'($countones(mask));
  endfunction

  // deposit the walk index into the unknown address lines
  function automatic logic [AW-1:0] candidate(input logic [AW-1:0] base, input logic [AW-1:0] mask,
                                              input logic [IW-1:0] idx);
    logic [AW-1:0] res;
    int j;
    res = base;
    j = 0;
    for (int b = 0; b < AW; b++) begin
      if (mask[b]) begin
        res[b] = idx[j];
        j++;
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  logic ae_ok, read_sel, write_sel, r_bad, w_bad, r_over, w_over, accept, bypass_hit;
  logic [AW-1:0] r_addr, r_unk, w_addr;
  logic [IW-1:0] r_cnt, w_cnt;

  // address enable gates the address-enabled RAM
  assign ae_ok = (VARIANT != memory_primitive_pkg::VARIANT_ADDRESS_ENABLED) || ctrl.address_enable;
  // output only when select, read enable and, on the address-enabled RAM, address enable are high
  assign read_sel = ctrl.chip_select && ctrl.read_enable && ae_ok;
  assign write_sel = ctrl.chip_select && ctrl.write_enable && ae_ok
                     && (VARIANT != memory_primitive_pkg::VARIANT_READ_ONLY);
  // separate equal-width read and write addresses on the dual-address RAM; the other variants share address
  assign r_addr = (VARIANT == memory_primitive_pkg::VARIANT_DUAL_ADDRESS) ? read_address : address;
  assign r_unk = (VARIANT == memory_primitive_pkg::VARIANT_DUAL_ADDRESS) ? read_address_unknown : address_unknown;
  assign w_addr = (VARIANT == memory_primitive_pkg::VARIANT_DUAL_ADDRESS) ? write_address : address;
  // highest reachable candidate against the limit
  assign r_bad = (r_addr | r_unk) > LAST_VALID_ADDRESS;
  assign w_bad = (w_addr | address_unknown) > LAST_VALID_ADDRESS;
  assign r_cnt = ones(r_unk);
  assign w_cnt = ones(address_unknown);
  // one threshold per instance, shared by both ports
  assign r_over = int'(r_cnt) > UNKNOWN_ADDRESS_THRESHOLD;
  assign w_over = int'(w_cnt) > UNKNOWN_ADDRESS_THRESHOLD;
  assign accept = (st.phase == memory_primitive_pkg::PHASE_IDLE) && !preload_enable;
  assign bypass_hit = read_sel && (r_unk == '0) && (address_unknown == '0) && (r_addr == w_addr);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic mem_we;
  logic [AW-1:0] mem_write_address, mem_read_address;
  logic [WW-1:0] mem_wword, mem_rword;
  logic [DW-1:0] rdata, runk, merged_unk;

  assign rdata = mem_rword[DW-1:0];
  assign runk = mem_rword[WW-1:DW];

  memory_word_store #(
    .ADDRESS_WIDTH(AW),
    .WORD_WIDTH(WW)
  ) u_store (
    .mclk(mclk),
    .resetn(resetn),
    .ce(ce),
    .write_en(mem_we),
    .write_address(mem_write_address),
    .write_word(mem_wword),
    .read_address(mem_read_address),
    .read_word(mem_rword)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    mem_we = 1'b0;
    mem_write_address = '0;
    mem_wword = '0;
    mem_read_address = (st.phase == memory_primitive_pkg::PHASE_IDLE) ? r_addr : candidate(st.base, st.umask, st.idx);
    merged_unk = st.acc_unk | runk | (st.acc ^ rdata);
    next_st.pend_upd = 1'b0;
    next_st.address_error = 1'b0;
    // result lands two edges after the request
    if (st.pend_upd) begin
      next_st.data_oe = st.pend_read;
      next_st.data_out = (st.pend_read && !st.pend_allx) ? (st.pend_bypass ? st.pend_wdata : rdata) : '0;
      next_st.data_unknown = !st.pend_read ? '0 : st.pend_allx ? {DW{1'b1}} : st.pend_bypass ? '0 : runk;
    end
    unique case (st.phase)
      memory_primitive_pkg::PHASE_IDLE: begin
        if (preload_enable) begin
          // address entry sets pointer, data fills upward
          if (preload_valid && preload_set_address) begin
            next_st.preload_ptr = preload_address;
          end else if (preload_valid) begin
            mem_we = 1'b1;
            mem_write_address = st.preload_ptr;
            mem_wword = {{DW{1'b0}}, preload_data};
            next_st.preload_ptr = st.preload_ptr + 1'b1;
          end
        end else begin
          next_st.pend_upd = 1'b1;
          next_st.pend_read = read_sel;
          next_st.pend_bypass = 1'b0;
          next_st.pend_allx = 1'b0;
          next_st.pend_wdata = write_data;
          next_st.idx = '0;
          // one-cycle flag for an out-of-range access
          next_st.address_error = (read_sel && r_bad) || (write_sel && w_bad);
          if (write_sel && !w_bad) begin
            if (address_unknown == '0) begin
              // store on this edge; same width as data out
              mem_we = 1'b1;
              mem_write_address = w_addr;
              mem_wword = {{DW{1'b0}}, write_data};
              // new word wins on a matching read
              next_st.pend_bypass = bypass_hit;
            end else if (w_over) begin
              // too many unknown lines spoil every location
              next_st.phase = memory_primitive_pkg::PHASE_WIPE;
            end else begin
              next_st.phase = memory_primitive_pkg::PHASE_SCAN_READ;
              next_st.op_write = 1'b1;
              next_st.base = w_addr;
              next_st.umask = address_unknown;
              next_st.last_idx = IW'((1 << w_cnt) - 1);
              next_st.wdata = write_data;
            end
          end
          if (read_sel && r_unk != '0) begin
            // read beyond the threshold, or behind a write walk
            if (r_over || next_st.phase != memory_primitive_pkg::PHASE_IDLE) begin
              next_st.pend_allx = 1'b1;
            end else begin
              next_st.pend_upd = 1'b0;
              next_st.phase = memory_primitive_pkg::PHASE_SCAN_READ;
              next_st.op_write = 1'b0;
              next_st.base = r_addr;
              next_st.umask = r_unk;
              next_st.last_idx = IW'((1 << r_cnt) - 1);
            end
          end
        end
      end
      memory_primitive_pkg::PHASE_SCAN_READ: begin
        next_st.phase = memory_primitive_pkg::PHASE_SCAN_USE;
      end
      memory_primitive_pkg::PHASE_SCAN_USE: begin
        if (st.op_write) begin
          // a maybe-written location keeps only agreeing bits known
          mem_we = 1'b1;
          mem_write_address = mem_read_address;
          mem_wword = {runk | (rdata ^ st.wdata), rdata};
        end else if (st.idx == '0) begin
          next_st.acc = rdata;
          next_st.acc_unk = runk;
        end else begin
          // bits that differ among candidates become unknown
          next_st.acc_unk = merged_unk;
        end
        if (st.idx == st.last_idx) begin
          next_st.phase = memory_primitive_pkg::PHASE_IDLE;
          if (!st.op_write) begin
            next_st.data_oe = 1'b1;
            next_st.data_out = next_st.acc;
            next_st.data_unknown = next_st.acc_unk;
          end
        end else begin
          next_st.idx = st.idx + 1'b1;
          next_st.phase = memory_primitive_pkg::PHASE_SCAN_READ;
        end
      end
      memory_primitive_pkg::PHASE_WIPE: begin
        // one location per cycle marked fully unknown
        mem_we = 1'b1;
        mem_write_address = st.idx[AW-1:0];
        mem_wword = {{DW{1'b1}}, {DW{1'b0}}};
        if (st.idx[AW-1:0] == {AW{1'b1}}) begin
          next_st.phase = memory_primitive_pkg::PHASE_IDLE;
        end else begin
          next_st.idx = st.idx + 1'b1;
        end
      end
    endcase
    next_st.busy = next_st.phase != memory_primitive_pkg::PHASE_IDLE;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign data_out = st.data_out;
  assign data_unknown = st.data_unknown;
  assign data_oe = st.data_oe;
  assign address_error = st.address_error;
  assign busy = st.busy;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk iff ce); endclocking
  default disable iff (!resetn);

  chk_width_range: assert property (AW >= 1 && AW <= memory_primitive_pkg::MAX_ADDRESS_WIDTH
    && DW >= 1 && DW <= memory_primitive_pkg::MAX_DATA_WIDTH) else $error("address or data width out of range");
  chk_write_store: assert property (accept && write_sel && !w_bad && address_unknown == '0
    |-> mem_we && mem_write_address == w_addr && mem_wword[DW-1:0] == write_data) else $error("enabled write not stored");
  chk_read_through: assert property (accept && write_sel && !w_bad && bypass_hit
    |=> ##1 data_oe && data_out == $past(write_data, 2) && data_unknown == '0)
    else $error("write and read did not return new word");
  chk_idle_release: assert property (accept && !read_sel |=> ##1 !data_oe)
    else $error("output driven without select and enables");
  chk_ae_gate: assert property (accept && VARIANT == memory_primitive_pkg::VARIANT_ADDRESS_ENABLED
    && !ctrl.address_enable |=> ##1 !data_oe) else $error("address enable low yet output driven");
  chk_range_flag: assert property (accept && ((read_sel && r_bad) || (write_sel && w_bad))
    |=> address_error) else $error("out-of-range access not flagged");
  chk_rom_store: assert property (VARIANT == memory_primitive_pkg::VARIANT_READ_ONLY && mem_we
    |-> preload_enable) else $error("read-only memory written outside preload");
  chk_overflow_read: assert property (accept && read_sel && r_over
    |=> ##1 data_oe && data_unknown == '1) else $error("over-threshold read not fully unknown");
  chk_wipe_word: assert property (st.phase == memory_primitive_pkg::PHASE_WIPE
    |-> mem_we && mem_wword[WW-1:DW] == '1 && busy) else $error("wipe did not spoil location");
  chk_preload_step: assert property (accept == 1'b0 && st.phase == memory_primitive_pkg::PHASE_IDLE
    && preload_enable && preload_valid && !preload_set_address
    |=> st.preload_ptr == $past(st.preload_ptr) + 1'b1) else $error("preload pointer did not advance");
  chk_scan_conflict: assert property (st.phase == memory_primitive_pkg::PHASE_SCAN_USE && !st.op_write
    && st.idx != '0 |=> (st.acc_unk & $past(st.acc ^ rdata)) == $past(st.acc ^ rdata))
    else $error("conflicting candidate bits left known");

endmodule

// *** tb/access_driver.sv ***
`timescale 1ns/10ps
module access_driver #(
  parameter int AW = 3,
  parameter int DW = 8
) (
  // clock
  input wire logic mclk,
  // preload stream
  output logic preload_enable,
  output logic preload_valid,
  output logic preload_set_address,
  output logic [AW-1:0] preload_address,
  output logic [DW-1:0] preload_data,
  // access
  output memory_primitive_pkg::access_ctrl_t ctrl,
  output logic [AW-1:0] address,
  output logic [AW-1:0] address_unknown,
  output logic [AW-1:0] read_address,
  output logic [AW-1:0] read_address_unknown,
  output logic [AW-1:0] write_address,
  output logic [DW-1:0] write_data
);
  // ------------------------------------------------------------
  // request side of the surrounding logic
  // ------------------------------------------------------------
  initial begin
    {preload_enable, preload_valid, preload_set_address} = 3'h0;
    {preload_address, preload_data, ctrl} = '0;
    {address, address_unknown, read_address, read_address_unknown, write_address, write_data} = '0;
  end

  // called just after a falling edge, held over the next rising edge
  task automatic req(input memory_primitive_pkg::access_ctrl_t c, input logic [AW-1:0] a, u, ra, ru, wa,
                     input logic [DW-1:0] d);
    ctrl = c;
    address = a;
    address_unknown = u;
    read_address = ra;
    read_address_unknown = ru;
    write_address = wa;
    write_data = d;
  endtask

  // released address and data lines flip and controls and unknown masks clear, so a stale value can never pass for a fresh one
  task automatic rest();
    ctrl = '0;
    address = ~address;
    address_unknown = '0;
    read_address = ~read_address;
    read_address_unknown = '0;
    write_address = ~write_address;
    write_data = ~write_data;
  endtask

  task automatic load(input logic [AW-1:0] start, input logic [4*DW-1:0] words, input int n);
    @(negedge mclk);
    {preload_enable, preload_valid, preload_set_address} = 3'h7;
    preload_address = start;
    for (int i = 0; i < n; i++) begin
      @(negedge mclk);
      preload_set_address = 1'b0;
      preload_address = ~preload_address;
      preload_data = words[(3-i)*DW +: DW];
    end
    @(negedge mclk);
    {preload_enable, preload_valid} = 2'h0;
    preload_data = ~preload_data;
  endtask
endmodule

// *** tb/tb_memory_primitive_set.sv ***
`timescale 1ns/10ps
module tb_memory_primitive_set;
  localparam int AW = 3;
  localparam int DW = 8;
  typedef logic [DW-1:0] word_t;
  typedef logic [AW-1:0] addr_t;

  // ------------------------------------------------------------
  // clock, reset, nets
  // ------------------------------------------------------------
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  int err_total = 0;
  int checks_done = 0;
  logic [3:0] err_seen;
  logic [3:0] busy_seen;
  wire logic pl_en, pl_valid, pl_set;
  wire addr_t pl_addr, a, au, ra, rau, wa;
  wire word_t pl_data, wd;
  wire memory_primitive_pkg::access_ctrl_t ctrl;
  wire logic [3:0][DW-1:0] q;
  wire logic [3:0][DW-1:0] qx;
  wire logic [3:0] oe, err, busy;

  always #2.5 mclk = ~mclk;

  access_driver #(.AW(AW), .DW(DW)) drv (
    .mclk(mclk), .preload_enable(pl_en), .preload_valid(pl_valid), .preload_set_address(pl_set),
    .preload_address(pl_addr), .preload_data(pl_data), .ctrl(ctrl), .address(a), .address_unknown(au),
    .read_address(ra), .read_address_unknown(rau), .write_address(wa), .write_data(wd)
  );

  // all four variants share one stimulus; threshold 1 keeps walks to two candidates
  for (genvar v = 0; v < 4; v++) begin : g_var
    memory_primitive_set #(
      .VARIANT(memory_primitive_pkg::variant_t'(v)), .ADDRESS_WIDTH(AW), .DATA_WIDTH(DW),
      .LAST_VALID_ADDRESS(3'h5), .UNKNOWN_ADDRESS_THRESHOLD(1)
    ) dut (
      .mclk(mclk), .resetn(resetn), .ce(ce), .preload_enable(pl_en), .preload_valid(pl_valid),
      .preload_set_address(pl_set), .preload_address(pl_addr), .preload_data(pl_data), .ctrl(ctrl),
      .address(a), .address_unknown(au), .read_address(ra), .read_address_unknown(rau),
      .write_address(wa), .write_data(wd), .data_out(q[v]), .data_unknown(qx[v]), .data_oe(oe[v]),
      .address_error(err[v]), .busy(busy[v])
    );
  end

  // ------------------------------------------------------------
  // compare and report
  // ------------------------------------------------------------
  task automatic cmp_w(input word_t got, input word_t exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t ns: %s is %h, wanted %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_b(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t ns: %s is %b, wanted %b", $time, what, got, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic see(input int v, input word_t e, input logic o);
    cmp_w(q[v], o ? e : 8'h00, "data");
    cmp_w(qx[v], 8'h00, "unknown mask");
    cmp_b(oe[v], o, "drive");
  endtask

  // one access, then wait until every variant is idle again
  task automatic acc(input logic [3:0] c, input addr_t adr, input addr_t unk, input addr_t radr,
                     input addr_t wadr, input word_t d);
    int n;
    @(negedge mclk);
    drv.req(memory_primitive_pkg::access_ctrl_t'(c), adr, unk, radr, unk, wadr, d);
    @(negedge mclk);
    err_seen = err;
    busy_seen = busy;
    drv.rest();
    for (n = 0; n < 64; n++) begin
      @(negedge mclk);
      if (busy === 4'h0) break;
    end
    if (n == 64) begin
      err_total++;
      $display("unexpected at %0t ns: busy never dropped", $time);
      final_report();
    end
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic s_preload();
    word_t img [6] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h24, 8'h25};
    drv.load(3'h0, 32'h1011_1213, 4);
    drv.load(3'h4, 32'h2425_0000, 2);
    for (int i = 0; i < 6; i++) begin
      acc(4'hD, addr_t'(i), 3'h0, addr_t'(i), addr_t'(i), 8'h00);
      for (int v = 0; v < 4; v++) see(v, img[i], 1'b1);
      cmp_w({4'h0, err_seen}, 8'h00, "range flag at or below limit");
    end
  endtask

  task automatic s_bypass();
    acc(4'hF, 3'h2, 3'h0, 3'h2, 3'h2, 8'hA5);
    see(0, 8'hA5, 1'b1);
    see(1, 8'hA5, 1'b1);
    see(2, 8'hA5, 1'b1);
    see(3, 8'h12, 1'b1);
    acc(4'hD, 3'h2, 3'h0, 3'h2, 3'h2, 8'h00);
    for (int v = 0; v < 3; v++) see(v, 8'hA5, 1'b1);
  endtask

  task automatic s_released();
    acc(4'h7, 3'h3, 3'h0, 3'h3, 3'h3, 8'h5A);
    for (int v = 0; v < 4; v++) see(v, 8'h00, 1'b0);
    acc(4'h9, 3'h3, 3'h0, 3'h3, 3'h3, 8'h00);
    for (int v = 0; v < 4; v++) see(v, 8'h00, 1'b0);
    acc(4'hD, 3'h3, 3'h0, 3'h3, 3'h3, 8'h00);
    for (int v = 0; v < 4; v++) see(v, 8'h13, 1'b1);
  endtask

  // clock enable low: a full request must neither store nor answer
  task automatic s_freeze();
    @(negedge mclk);
    ce = 1'b0;
    drv.req(memory_primitive_pkg::access_ctrl_t'(4'hF), 3'h3, 3'h0, 3'h3, 3'h0, 3'h3, 8'h5A);
    repeat (3) @(negedge mclk);
    for (int v = 0; v < 4; v++) see(v, 8'h00, 1'b0);
    drv.rest();
    ce = 1'b1;
    acc(4'hD, 3'h3, 3'h0, 3'h3, 3'h3, 8'h00);
    for (int v = 0; v < 4; v++) see(v, 8'h13, 1'b1);
  endtask

  task automatic s_addr_enable();
    acc(4'hE, 3'h1, 3'h0, 3'h1, 3'h1, 8'hC3);
    see(0, 8'hC3, 1'b1);
    see(1, 8'hC3, 1'b1);
    see(2, 8'h00, 1'b0);
    see(3, 8'h11, 1'b1);
    acc(4'hD, 3'h1, 3'h0, 3'h1, 3'h1, 8'h00);
    see(2, 8'h11, 1'b1);
  endtask

  task automatic s_dual();
    acc(4'hF, 3'h4, 3'h0, 3'h5, 3'h4, 8'h77);
    see(1, 8'h25, 1'b1);
    see(0, 8'h77, 1'b1);
    acc(4'hD, 3'h4, 3'h0, 3'h4, 3'h4, 8'h00);
    see(1, 8'h77, 1'b1);
    see(3, 8'h24, 1'b1);
  endtask

  task automatic s_range();
    acc(4'hF, 3'h6, 3'h0, 3'h6, 3'h6, 8'h99);
    cmp_w({4'h0, err_seen}, 8'h0F, "range flag");
    cmp_w({4'h0, err}, 8'h00, "range flag after its cycle");
  endtask

  task automatic s_unknown();
    word_t c0 [4] = '{8'h10, 8'h10, 8'h10, 8'h10};
    word_t c1 [4] = '{8'hC3, 8'hC3, 8'h11, 8'h11};
    word_t m;
    acc(4'hD, 3'h0, 3'h1, 3'h0, 3'h0, 8'h00);
    cmp_w({4'h0, busy_seen}, 8'h0F, "walk busy");
    for (int v = 0; v < 4; v++) begin
      m = c0[v] ^ c1[v];
      cmp_w(qx[v], m, "unknown mask");
      cmp_w(q[v] & ~m, c0[v] & ~m, "agreed bits");
    end
  endtask

  task automatic s_over();
    acc(4'hD, 3'h0, 3'h3, 3'h0, 3'h0, 8'h00);
    for (int v = 0; v < 4; v++) begin
      cmp_w(q[v], 8'h00, "data");
      cmp_w(qx[v], 8'hFF, "unknown mask");
    end
    acc(4'hB, 3'h0, 3'h3, 3'h0, 3'h0, 8'h00);
    acc(4'hD, 3'h2, 3'h0, 3'h2, 3'h2, 8'h00);
    for (int v = 0; v < 3; v++) cmp_w(qx[v], 8'hFF, "wiped word");
    see(3, 8'h12, 1'b1);
  endtask

  initial begin
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    resetn = 1'b1;
    s_preload();
    s_bypass();
    s_released();
    s_freeze();
    s_addr_enable();
    s_dual();
    s_range();
    s_unknown();
    s_over();
    final_report();
  end
endmodule
